/* File: msr_consts.vh */
// constants shared by the sensor slave and its serial helpers
// assumes a single 50 MHz system clock
`ifndef MSR_CONSTS_VH
`define MSR_CONSTS_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define MSR_CLK_HZ 50000000
// 3 s and 10 s counted in sys_clk cycles
`define MSR_LONG_PRESS_CYC 29'h8F0D180
`define MSR_IDLE_EXIT_CYC 29'h1DCD6500
// quiet line of 3.5 characters, in bit times
`define MSR_GAP_BITS 6'h23

// ----------------------------------------
// line rates: cycles per bit and codes
// ----------------------------------------
`define MSR_DIV_2400 15'h5161
`define MSR_DIV_4800 15'h28B1
`define MSR_DIV_9600 15'h1458
`define MSR_DIV_19200 15'h0A2C
`define MSR_RATE_2400 3'h1
`define MSR_RATE_4800 3'h2
`define MSR_RATE_9600 3'h3
`define MSR_RATE_19200 3'h4
`define MSR_RATE_DEFAULT 3'h3
`define MSR_STATION_DEFAULT 8'h01

// ----------------------------------------
// protocol
// ----------------------------------------
`define MSR_REG_TEMP 16'h0000
`define MSR_REG_HUMID 16'h0001
`define MSR_REG_STATION 16'h07D0
`define MSR_REG_RATE 16'h0BB8
`define MSR_FC_READ 8'h03
`define MSR_FC_WRITE 8'h06
`define MSR_REQ_LAST 4'h7
`define MSR_REQ_FULL 4'h8
`define MSR_MAX_READ 16'h0008
`define MSR_WR_LEN 8'h02
`define MSR_WR_REPLY_LEN 5'h07
`define MSR_RD_HDR_LEN 5'h05
`define MSR_DATA_START 5'h03
`define MSR_CRC_INIT 16'hFFFF
`define MSR_CRC_POLY 16'hA001

// ----------------------------------------
// buttons
// ----------------------------------------
`define MSR_BTN_MENU 0
`define MSR_BTN_UP 1
`define MSR_BTN_DOWN 2
`define MSR_BTN_ENTER 3

`endif

/* File: msr_uart_rx.v */
// serial receiver: start, 8 data bits lsb first, stop, no parity
// assumes rxPin is asynchronous; bitDiv is cycles per bit
`include "msr_consts.vh"

module msr_uart_rx (
  input wire sys_clk,
  input wire rst,
  input wire rxPin,
  input wire [14:0] bitDiv,
  output reg byteValid,
  output reg [7:0] byteData
);
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_START = 4'h2;
  localparam [3:0] ST_DATA = 4'h4;
  localparam [3:0] ST_STOP = 4'h8;

  reg sync1_r;
  reg sync2_r;
  reg [3:0] state_r;
  reg [14:0] cnt_r;
  reg [2:0] bitIdx_r;
  reg [7:0] shift_r;

  always @(posedge sys_clk) begin
    if (rst) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      state_r <= ST_IDLE;
      cnt_r <= 15'h0000;
      bitIdx_r <= 3'h0;
      shift_r <= 8'h00;
      byteValid <= 1'b0;
      byteData <= 8'h00;
    end else begin
      sync1_r <= rxPin;
      sync2_r <= sync1_r;
      byteValid <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (!sync2_r) begin
            state_r <= ST_START;
            cnt_r <= bitDiv >> 1;
          end
        end
        ST_START: begin
          if (cnt_r == 15'h0000) begin
            // a glitch shorter than half a bit is not a start
            state_r <= sync2_r ? ST_IDLE : ST_DATA;
            cnt_r <= bitDiv - 15'h0001;
            bitIdx_r <= 3'h0;
          end else begin
            cnt_r <= cnt_r - 15'h0001;
          end
        end
        ST_DATA: begin
          if (cnt_r == 15'h0000) begin
            shift_r <= {sync2_r, shift_r[7:1]};
            cnt_r <= bitDiv - 15'h0001;
            bitIdx_r <= bitIdx_r + 3'h1;
            if (bitIdx_r == 3'h7) begin
              state_r <= ST_STOP;
            end
          end else begin
            cnt_r <= cnt_r - 15'h0001;
          end
        end
        ST_STOP: begin
          if (cnt_r == 15'h0000) begin
            // framing error: byte dropped
            byteValid <= sync2_r;
            byteData <= shift_r;
            state_r <= ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 15'h0001;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule

/* File: msr_uart_tx.v */
// serial transmitter: start, 8 data bits lsb first, one stop bit
// assumes txStart is a one-cycle pulse given only while txBusy is low
`include "msr_consts.vh"

module msr_uart_tx (
  input wire sys_clk,
  input wire rst,
  input wire [14:0] bitDiv,
  input wire txStart,
  input wire [7:0] txByte,
  output wire txdPin,
  output reg txBusy,
  output reg txDone
);
  reg [9:0] shift_r;
  reg [14:0] cnt_r;
  reg [3:0] bitsLeft_r;

  assign txdPin = shift_r[0];

  always @(posedge sys_clk) begin
    if (rst) begin
      shift_r <= 10'h3FF;
      cnt_r <= 15'h0000;
      bitsLeft_r <= 4'h0;
      txBusy <= 1'b0;
      txDone <= 1'b0;
    end else begin
      txDone <= 1'b0;
      if (!txBusy) begin
        if (txStart) begin
          shift_r <= {1'b1, txByte, 1'b0};
          cnt_r <= bitDiv - 15'h0001;
          bitsLeft_r <= 4'hA;
          txBusy <= 1'b1;
        end
      end else if (cnt_r != 15'h0000) begin
        cnt_r <= cnt_r - 15'h0001;
      end else if (bitsLeft_r == 4'h1) begin
        txBusy <= 1'b0;
        txDone <= 1'b1;
      end else begin
        shift_r <= {1'b1, shift_r[9:1]};
        cnt_r <= bitDiv - 15'h0001;
        bitsLeft_r <= bitsLeft_r - 4'h1;
      end
    end
  end
endmodule

/* File: msr_sensor_slave.v */
// serial-bus slave of a temperature and humidity transmitter, with its
// local button menu for station number and line rate
// assumes readings arrive on sys_clk; buttons and rx line are pins
`include "msr_consts.vh"

// Functional notes
// - characters are start bit, eight data bits, one stop bit, no parity.
// - after reset the station is one and the rate is 9600.
// - rates 2400, 4800, 9600 and 19200 are selectable.
// - rate codes 1..4 mean 2400, 4800, 9600, 19200.
// - read request is station, 0x03, start, count, crc.
// - read reply is station, 0x03, byte count, words, crc.
// - write request is station, 0x06, register, value, crc; reply carries the value now held.
// - register 0x0000 returns temperature in hundredths of a degree.
// - register 0x0001 returns humidity in hundredths of a percent.
// - writing register 0x0bb8 sets the line-rate code.
// - writing register 0x07d0 sets the station number, range 1..255.
// - menu held three seconds opens settings showing the station number.
// - short menu press moves to the rate; up and down step rates.
// - enter held three seconds commits settings and returns home.
// - ten seconds without button activity leaves the settings view.
module msr_sensor_slave #(
  parameter [28:0] LONG_PRESS_CYC = `MSR_LONG_PRESS_CYC,
  parameter [28:0] IDLE_EXIT_CYC = `MSR_IDLE_EXIT_CYC,
  parameter [3:0] DIV_SHIFT = 4'h0 // nonzero only to shorten simulation
) (
  input wire sys_clk,
  input wire rst,
  input wire rs485RxPin,
  output wire rs485TxPin,
  output wire rs485DriveEn,
  input wire [15:0] temperatureIn,
  input wire [15:0] humidityIn,
  input wire btnMenuPin,
  input wire btnUpPin,
  input wire btnDownPin,
  input wire btnEnterPin,
  output wire viewStation,
  output wire viewRate,
  output reg [7:0] editStation_r,
  output reg [2:0] editRate_r,
  output reg [7:0] stationSet_r,
  output reg [2:0] rateSet_r
);
  localparam [2:0] ST_RX = 3'h1;
  localparam [2:0] ST_TX_LOAD = 3'h2;
  localparam [2:0] ST_TX_WAIT = 3'h4;
  localparam [2:0] MN_HOME = 3'h1;
  localparam [2:0] MN_STATION = 3'h2;
  localparam [2:0] MN_RATE = 3'h4;
  localparam [28:0] LONG_HIT = LONG_PRESS_CYC - 29'h0000001;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [15:0] crcByte;
    input [15:0] c;
    input [7:0] b;
    integer k;
    reg [15:0] t;
    begin
      t = c ^ {8'h00, b};
      for (k = 0; k < 8; k = k + 1) begin
        t = t[0] ? ((t >> 1) ^ `MSR_CRC_POLY) : (t >> 1);
      end
      crcByte = t;
    end
  endfunction

  function [14:0] divFor;
    input [2:0] code;
    begin
      case (code)
        `MSR_RATE_2400: divFor = `MSR_DIV_2400;
        `MSR_RATE_4800: divFor = `MSR_DIV_4800;
        `MSR_RATE_19200: divFor = `MSR_DIV_19200;
        default: divFor = `MSR_DIV_9600;
      endcase
    end
  endfunction

  // ----------------------------------------
  // serial engines on the active rate
  // ----------------------------------------
  reg [2:0] state_r;
  reg [7:0] stationAct_r;
  reg [2:0] rateAct_r;
  reg applyPend_r;
  reg txStart_r;
  reg [7:0] txByte_r;
  wire [14:0] bitDiv;
  wire rxValid;
  wire [7:0] rxByte;
  wire txDone;

  assign bitDiv = divFor(rateAct_r) >> DIV_SHIFT;

  msr_uart_rx u_rx (
    .sys_clk(sys_clk),
    .rst(rst),
    .rxPin(rs485RxPin),
    .bitDiv(bitDiv),
    .byteValid(rxValid),
    .byteData(rxByte)
  );

  msr_uart_tx u_tx (
    .sys_clk(sys_clk),
    .rst(rst),
    .bitDiv(bitDiv),
    .txStart(txStart_r),
    .txByte(txByte_r),
    .txdPin(rs485TxPin),
    .txBusy(rs485DriveEn),
    .txDone(txDone)
  );

  // ----------------------------------------
  // request capture
  // ----------------------------------------
  reg [7:0] rxBuf_r [0:7];
  reg [3:0] rxCnt_r;
  reg [15:0] crcRx_r;
  reg frameDone_r;
  reg [14:0] tickCnt_r;
  reg [5:0] gapCnt_r;
  wire bitTick = (tickCnt_r == 15'h0000);
  wire [15:0] reqReg = {rxBuf_r[2], rxBuf_r[3]};
  wire [15:0] reqVal = {rxBuf_r[4], rxBuf_r[5]};

  always @(posedge sys_clk) begin
    if (rst) begin
      tickCnt_r <= 15'h0000;
      gapCnt_r <= 6'h00;
    end else begin
      tickCnt_r <= bitTick ? bitDiv - 15'h0001 : tickCnt_r - 15'h0001;
      if (rxValid) begin
        gapCnt_r <= 6'h00;
      end else if (bitTick && gapCnt_r != `MSR_GAP_BITS) begin
        gapCnt_r <= gapCnt_r + 6'h01;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      rxCnt_r <= 4'h0;
      crcRx_r <= `MSR_CRC_INIT;
      frameDone_r <= 1'b0;
    end else begin
      frameDone_r <= 1'b0;
      if ((gapCnt_r == `MSR_GAP_BITS && !rxValid) || state_r != ST_RX) begin
        // a quiet line ends any partial frame; own echo is not heard
        rxCnt_r <= 4'h0;
        crcRx_r <= `MSR_CRC_INIT;
      end else if (rxValid && rxCnt_r != `MSR_REQ_FULL) begin
        rxBuf_r[rxCnt_r[2:0]] <= rxByte;
        crcRx_r <= crcByte(crcRx_r, rxByte);
        rxCnt_r <= rxCnt_r + 4'h1;
        frameDone_r <= (rxCnt_r == `MSR_REQ_LAST);
      end
    end
  end

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  // crc over the whole frame leaves zero
  // only our own station is served
  wire frameOk = frameDone_r && crcRx_r == 16'h0000 && rxBuf_r[0] == stationAct_r;
  wire isRead = rxBuf_r[1] == `MSR_FC_READ && reqVal != 16'h0000 &&
                reqVal <= `MSR_MAX_READ;
  wire isWrite = rxBuf_r[1] == `MSR_FC_WRITE;
  wire isWrSt = isWrite && reqReg == `MSR_REG_STATION;
  wire isWrRt = isWrite && reqReg == `MSR_REG_RATE;
  // station zero and unknown rate codes refused
  wire stOk = reqVal[15:8] == 8'h00 && reqVal[7:0] != 8'h00;
  wire rtOk = reqVal >= {13'h0000, `MSR_RATE_2400} &&
              reqVal <= {13'h0000, `MSR_RATE_19200};
  wire wrStation = frameOk && isWrSt && stOk;
  wire wrRate = frameOk && isWrRt && rtOk;

  // ----------------------------------------
  // reply generation
  // ----------------------------------------
  reg [4:0] txIdx_r;
  reg [4:0] txLen_r;
  reg [7:0] fc_r;
  reg [7:0] dataLen_r;
  reg [15:0] rdBase_r;
  reg [15:0] wrVal_r;
  reg [15:0] crcTx_r;
  reg [7:0] txNext;
  reg [15:0] rdWord;
  wire [4:0] dataOff = txIdx_r - `MSR_DATA_START;
  wire [15:0] rdAddr = rdBase_r + {12'h000, dataOff[4:1]};
  wire [15:0] dataWord = (fc_r == `MSR_FC_READ) ? rdWord : wrVal_r;

  always @* begin
    case (rdAddr)
      `MSR_REG_TEMP: rdWord = temperatureIn;
      `MSR_REG_HUMID: rdWord = humidityIn;
      `MSR_REG_STATION: rdWord = {8'h00, stationSet_r};
      `MSR_REG_RATE: rdWord = {13'h0000, rateSet_r};
      default: rdWord = 16'h0000;
    endcase
  end

  always @* begin
    // station, function, count, words, crc low then high
    if (txIdx_r == 5'h00) begin
      txNext = stationAct_r;
    end else if (txIdx_r == 5'h01) begin
      txNext = fc_r;
    end else if (txIdx_r == 5'h02) begin
      txNext = dataLen_r;
    end else if (txIdx_r == txLen_r - 5'h02) begin
      txNext = crcTx_r[7:0];
    end else if (txIdx_r == txLen_r - 5'h01) begin
      txNext = crcTx_r[15:8];
    end else begin
      txNext = dataOff[0] ? dataWord[7:0] : dataWord[15:8];
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      state_r <= ST_RX;
      txIdx_r <= 5'h00;
      txLen_r <= 5'h00;
      fc_r <= 8'h00;
      dataLen_r <= 8'h00;
      rdBase_r <= 16'h0000;
      wrVal_r <= 16'h0000;
      crcTx_r <= `MSR_CRC_INIT;
      txStart_r <= 1'b0;
      txByte_r <= 8'h00;
    end else begin
      txStart_r <= 1'b0;
      case (state_r)
        ST_RX: begin
          txIdx_r <= 5'h00;
          crcTx_r <= `MSR_CRC_INIT;
          fc_r <= rxBuf_r[1];
          if (frameOk && isRead) begin
            txLen_r <= `MSR_RD_HDR_LEN + {reqVal[3:0], 1'b0};
            dataLen_r <= {3'h0, reqVal[3:0], 1'b0};
            rdBase_r <= reqReg;
            state_r <= ST_TX_LOAD;
          end else if (frameOk && (isWrSt || isWrRt)) begin
            // reply carries the register value now held
            txLen_r <= `MSR_WR_REPLY_LEN;
            dataLen_r <= `MSR_WR_LEN;
            if (isWrSt) begin
              wrVal_r <= {8'h00, stOk ? reqVal[7:0] : stationSet_r};
            end else begin
              wrVal_r <= {13'h0000, rtOk ? reqVal[2:0] : rateSet_r};
            end
            state_r <= ST_TX_LOAD;
          end
        end
        ST_TX_LOAD: begin
          txByte_r <= txNext;
          txStart_r <= 1'b1;
          // crc covers all bytes before it
          if (txIdx_r < txLen_r - 5'h02) begin
            crcTx_r <= crcByte(crcTx_r, txNext);
          end
          state_r <= ST_TX_WAIT;
        end
        ST_TX_WAIT: begin
          if (txDone) begin
            txIdx_r <= txIdx_r + 5'h01;
            state_r <= (txIdx_r == txLen_r - 5'h01) ? ST_RX : ST_TX_LOAD;
          end
        end
        default: state_r <= ST_RX;
      endcase
    end
  end

  // ----------------------------------------
  // buttons: sync, edge, long hold
  // ----------------------------------------
  wire [3:0] btnRaw = {btnEnterPin, btnDownPin, btnUpPin, btnMenuPin};
  wire [3:0] btnHeld;
  wire [3:0] btnPress;
  wire [3:0] btnShort;
  wire [3:0] btnLong;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_btn
      reg sync1_r;
      reg sync2_r;
      reg prev_r;
      reg [28:0] hold_r;
      always @(posedge sys_clk) begin
        if (rst) begin
          sync1_r <= 1'b0;
          sync2_r <= 1'b0;
          prev_r <= 1'b0;
          hold_r <= 29'h0000000;
        end else begin
          sync1_r <= btnRaw[g];
          sync2_r <= sync1_r;
          prev_r <= sync2_r;
          if (!sync2_r) begin
            hold_r <= 29'h0000000;
          end else if (hold_r != LONG_PRESS_CYC) begin
            hold_r <= hold_r + 29'h0000001;
          end
        end
      end
      assign btnHeld[g] = sync2_r;
      assign btnPress[g] = sync2_r & ~prev_r;
      // released before the long mark counts as a short press
      assign btnShort[g] = ~sync2_r & prev_r & (hold_r != LONG_PRESS_CYC);
      assign btnLong[g] = sync2_r & (hold_r == LONG_HIT);
    end
  endgenerate

  // ----------------------------------------
  // settings menu
  // ----------------------------------------
  reg [2:0] menu_r;
  reg [28:0] idle_r;
  wire menuCommit = btnLong[`MSR_BTN_ENTER] && menu_r != MN_HOME;
  wire up = btnPress[`MSR_BTN_UP];
  wire down = btnPress[`MSR_BTN_DOWN];

  assign viewStation = menu_r[1];
  assign viewRate = menu_r[2];

  always @(posedge sys_clk) begin
    if (rst) begin
      menu_r <= MN_HOME;
      idle_r <= 29'h0000000;
      editStation_r <= `MSR_STATION_DEFAULT;
      editRate_r <= `MSR_RATE_DEFAULT;
    end else begin
      idle_r <= (|btnHeld) ? 29'h0000000 : idle_r + 29'h0000001;
      case (menu_r)
        MN_HOME: begin
          idle_r <= 29'h0000000;
          // long menu opens the station view
          if (btnLong[`MSR_BTN_MENU]) begin
            menu_r <= MN_STATION;
            editStation_r <= stationSet_r;
            editRate_r <= rateSet_r;
          end
        end
        MN_STATION: begin
          // short menu moves to the rate view
          if (btnShort[`MSR_BTN_MENU]) begin
            menu_r <= MN_RATE;
          end else if (up) begin
            editStation_r <= (editStation_r == 8'hFF) ? 8'h01 : editStation_r + 8'h01;
          end else if (down) begin
            editStation_r <= (editStation_r == 8'h01) ? 8'hFF : editStation_r - 8'h01;
          end
        end
        MN_RATE: begin
          // up and down step the rates, wrapping
          if (btnShort[`MSR_BTN_MENU]) begin
            menu_r <= MN_STATION;
          end else if (up) begin
            editRate_r <= (editRate_r == `MSR_RATE_19200) ? `MSR_RATE_2400 :
                          editRate_r + 3'h1;
          end else if (down) begin
            editRate_r <= (editRate_r == `MSR_RATE_2400) ? `MSR_RATE_19200 :
                          editRate_r - 3'h1;
          end
        end
        default: menu_r <= MN_HOME;
      endcase
      // long enter commits and goes home
      if (menuCommit) begin
        menu_r <= MN_HOME;
      end
      if (menu_r != MN_HOME && idle_r == IDLE_EXIT_CYC) begin
        menu_r <= MN_HOME;
      end
    end
  end

  // ----------------------------------------
  // stored and active settings
  // ----------------------------------------
  // applied only while no reply is in flight, so a reply finishes
  // at the rate and station it began with
  wire applyNow = applyPend_r && state_r == ST_RX && !frameDone_r;

  always @(posedge sys_clk) begin
    if (rst) begin
      // station one at 9600 after reset
      stationSet_r <= `MSR_STATION_DEFAULT;
      rateSet_r <= `MSR_RATE_DEFAULT;
      stationAct_r <= `MSR_STATION_DEFAULT;
      rateAct_r <= `MSR_RATE_DEFAULT;
      applyPend_r <= 1'b0;
    end else begin
      if (menuCommit) begin
        stationSet_r <= editStation_r;
        rateSet_r <= editRate_r;
      end
      if (wrStation) begin
        stationSet_r <= reqVal[7:0];
      end
      if (wrRate) begin
        rateSet_r <= reqVal[2:0];
      end
      // switch over once the reply is out
      if (applyNow) begin
        stationAct_r <= stationSet_r;
        rateAct_r <= rateSet_r;
      end
      applyPend_r <= wrStation | wrRate | menuCommit | (applyPend_r & ~applyNow);
    end
  end
endmodule

/* File: msr_slave_monitor.sv */
// checker for the sensor slave: reset values, serial framing, menu
// assumes it is bound into msr_sensor_slave and sees only its ports
module msr_slave_monitor #(
  parameter [28:0] LONG_PRESS_CYC = 29'h0000014,
  parameter [28:0] IDLE_EXIT_CYC = 29'h0000064
) (
  input wire sys_clk,
  input wire rst,
  input wire rs485RxPin,
  input wire rs485TxPin,
  input wire rs485DriveEn,
  input wire [15:0] temperatureIn,
  input wire [15:0] humidityIn,
  input wire btnMenuPin,
  input wire btnUpPin,
  input wire btnDownPin,
  input wire btnEnterPin,
  input wire viewStation,
  input wire viewRate,
  input wire [7:0] editStation_r,
  input wire [2:0] editRate_r,
  input wire [7:0] stationSet_r,
  input wire [2:0] rateSet_r
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  reg menuQ_r;
  reg [31:0] menuLen_r;
  reg [31:0] idleCnt_r;
  wire anyBtn = btnMenuPin | btnUpPin | btnDownPin | btnEnterPin;
  // length of the last menu press, kept after release
  always @(posedge sys_clk) begin
    menuQ_r <= btnMenuPin;
    if (rst) begin
      menuLen_r <= 32'h0;
    end else if (btnMenuPin) begin
      menuLen_r <= menuQ_r ? menuLen_r + 32'h1 : 32'h1;
    end
  end
  always @(posedge sys_clk) begin
    if (rst || anyBtn || !(viewStation || viewRate)) begin
      idleCnt_r <= 32'h0;
    end else begin
      idleCnt_r <= idleCnt_r + 32'h1;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence openFromHome;
    $rose(viewStation) && !$past(viewRate);
  endsequence
  AST_RESET_VALUES: assert property (disable iff (1'b0) rst |=>
    stationSet_r == 8'h01 && rateSet_r == 3'h3 && !rs485DriveEn && !viewStation)
    else $error("reset values wrong");
  AST_RATE_CODE_RANGE: assert property (rateSet_r >= 3'h1 && rateSet_r <= 3'h4)
    else $error("stored rate code out of range");
  AST_STATION_NONZERO: assert property (stationSet_r != 8'h00)
    else $error("stored station is zero");
  AST_LINE_IDLE_HIGH: assert property (!rs485DriveEn |-> rs485TxPin)
    else $error("line not high while released");
  AST_START_WITH_ENABLE: assert property ($rose(rs485DriveEn) |-> !rs485TxPin)
    else $error("character does not open with start bit");
  AST_CHAR_HOLDS: assert property ($rose(rs485DriveEn) |=> rs485DriveEn [*8])
    else $error("driver released inside a character");
  AST_ONE_VIEW: assert property (!(viewStation && viewRate))
    else $error("two settings views at once");
  AST_EDIT_RANGES: assert property (editRate_r >= 3'h1 && editRate_r <= 3'h4
    && editStation_r != 8'h00) else $error("edit value out of range");
  AST_OPEN_LONG_PRESS: assert property (openFromHome |->
    menuLen_r >= {3'h0, LONG_PRESS_CYC}) else $error("menu opened on short press");
  AST_OPEN_LOADS_STATION: assert property (openFromHome |->
    ##[0:1] editStation_r == stationSet_r) else $error("menu shows wrong station");
  AST_IDLE_EXIT: assert property (idleCnt_r <= {3'h0, IDLE_EXIT_CYC} + 32'h8)
    else $error("settings view kept while idle");
endmodule

bind msr_sensor_slave msr_slave_monitor #(
  .LONG_PRESS_CYC(LONG_PRESS_CYC),
  .IDLE_EXIT_CYC(IDLE_EXIT_CYC)
) mon (.*);

/* File: msr_master_model.sv */
// bus master model: sends requests, collects reply characters
// assumes the line is biased high when nobody drives it
module msr_master_model (
  input wire sys_clk,
  output logic lineOut,
  input wire lineIn,
  input wire driveEn
);
  timeunit 1ns;
  timeprecision 1ps;
  int bitCyc = 5208;
  int stopErr = 0;
  logic [7:0] rxQ[$];
  initial lineOut = 1'b1;
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  task automatic put_bit(input logic b);
    #1 lineOut = b;
    repeat (bitCyc) @(posedge sys_clk);
  endtask
  task automatic send_req(input logic [7:0] st, fc, input logic [15:0] a, v, input logic bad);
    logic [7:0] q[$];
    logic [15:0] c;
    q = {st, fc, a[15:8], a[7:0], v[15:8], v[7:0]};
    c = crc16(q) ^ {15'h0, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    // start, 8 data lsb first, stop
    foreach (q[i]) begin
      put_bit(1'b0);
      for (int k = 0; k < 8; k++) put_bit(q[i][k]);
      put_bit(1'b1);
    end
  endtask
  // sampled on the falling edge to stay clear of the slave's updates
  always begin
    logic [7:0] b;
    @(negedge sys_clk iff (driveEn && !lineIn));
    repeat (bitCyc / 2) @(negedge sys_clk);
    for (int k = 0; k < 8; k++) begin
      repeat (bitCyc) @(negedge sys_clk);
      b[k] = lineIn;
    end
    repeat (bitCyc) @(negedge sys_clk);
    if (lineIn !== 1'b1) stopErr++;
    rxQ.push_back(b);
  end
endmodule

/* File: tb.sv */
// testbench: register traffic over the serial line, menu, reset
// assumes the master model on the line, shortened menu counts and bit times
`include "msr_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] fc; logic [15:0] rg, val, w0, w1; logic [2:0] rate; int bc;} msr_row_t;
  logic sys_clk, rst;
  logic [3:0] btn;
  logic [15:0] temperatureIn = 16'h0B8F;
  logic [15:0] humidityIn = 16'h1B85;
  wire rs485RxPin, rs485TxPin, rs485DriveEn, viewStation, viewRate;
  wire btnMenuPin = btn[`MSR_BTN_MENU];
  wire btnUpPin = btn[`MSR_BTN_UP];
  wire btnDownPin = btn[`MSR_BTN_DOWN];
  wire btnEnterPin = btn[`MSR_BTN_ENTER];
  wire [7:0] editStation_r, stationSet_r;
  wire [2:0] editRate_r, rateSet_r;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  // bit divisors shrunk 64 times to keep the run short
  localparam logic [3:0] SH = 4'h6;
  msr_row_t rows[4] = '{
    '{8'h03, 16'h0000, 16'h0002, 16'h0B8F, 16'h1B85, 3'h3, `MSR_DIV_9600 >> SH},
    '{8'h06, 16'h0BB8, 16'h0004, 16'h0004, 16'h0000, 3'h4, `MSR_DIV_9600 >> SH},
    '{8'h06, 16'h0BB8, 16'h0000, 16'h0004, 16'h0000, 3'h4, `MSR_DIV_19200 >> SH},
    '{8'h06, 16'h07D0, 16'h0000, 16'h0001, 16'h0000, 3'h4, `MSR_DIV_19200 >> SH}};
  msr_sensor_slave #(.LONG_PRESS_CYC(29'h0000014), .IDLE_EXIT_CYC(29'h0000064),
    .DIV_SHIFT(SH)) DUT (.*);
  msr_master_model master (
    .sys_clk(sys_clk),
    .lineOut(rs485RxPin),
    .lineIn(rs485TxPin),
    .driveEn(rs485DriveEn)
  );
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    if (bad_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic press(input int idx, input int len);
    #1 btn[idx] = 1'b1;
    repeat (len) @(posedge sys_clk);
    #1 btn[idx] = 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic run_row(input msr_row_t r);
    logic [7:0] e[$];
    logic [15:0] c;
    int n;
    master.bitCyc = r.bc;
    e = {8'h01, r.fc};
    if (r.fc == 8'h03) e = {e, 8'h04, r.w0[15:8], r.w0[7:0], r.w1[15:8], r.w1[7:0]};
    else e = {e, 8'h02, r.w0[15:8], r.w0[7:0]};
    master.rxQ.delete();
    @(posedge sys_clk);
    master.send_req(8'h01, r.fc, r.rg, r.val, 1'b0);
    n = 0;
    while (master.rxQ.size() < e.size() + 2 && n < 200 * r.bc) begin
      @(posedge sys_clk);
      n++;
    end
    foreach (e[i]) chk(master.rxQ[i], e[i]);
    c = master.crc16(e);
    chk({master.rxQ[e.size() + 1], master.rxQ[e.size()]}, c);
    repeat (36 * r.bc) @(posedge sys_clk);
    chk(rateSet_r, r.rate);
    chk(stationSet_r, 8'h01);
  endtask
  // ----------------------------------------
  // clock, timeout, main sequence
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // serial traffic dominates: about 60 thousand cycles expected
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 80000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    rst = 1'b1;
    btn = 4'h0;
    repeat (16) @(posedge sys_clk);
    #1 rst = 1'b0;
    @(posedge sys_clk);
    chk({stationSet_r, 5'h0, rateSet_r}, 16'h0103);
    foreach (rows[i]) run_row(rows[i]);
    chk(master.stopErr[15:0], 16'h0000);
    // wrong check word, then foreign station: both stay unanswered
    for (int i = 0; i < 2; i++) begin
      master.rxQ.delete();
      master.send_req(i ? 8'h02 : 8'h01, 8'h03, 16'h0000, 16'h0001, !i);
      repeat (40 * master.bitCyc) @(posedge sys_clk);
      chk(master.rxQ.size(), 16'h0000);
    end
    press(`MSR_BTN_MENU, 30);
    chk({viewStation, editStation_r}, 9'h101);
    press(`MSR_BTN_UP, 3);
    chk(editStation_r, 8'h02);
    press(`MSR_BTN_DOWN, 3);
    press(`MSR_BTN_DOWN, 3);
    chk(editStation_r, 8'hFF);
    press(`MSR_BTN_MENU, 3);
    chk({viewStation, viewRate, editRate_r}, 5'h0C);
    press(`MSR_BTN_UP, 3);
    chk(editRate_r, 3'h1);
    press(`MSR_BTN_ENTER, 30);
    chk({viewStation, viewRate, 2'h0, stationSet_r, 1'b0, rateSet_r}, 16'h0FF1);
    press(`MSR_BTN_MENU, 30);
    press(`MSR_BTN_UP, 3);
    repeat (120) @(posedge sys_clk);
    chk({viewStation, viewRate, stationSet_r}, 10'h0FF);
    #1 rst = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 rst = 1'b0;
    @(posedge sys_clk);
    chk({stationSet_r, 5'h0, rateSet_r}, 16'h0103);
    report_and_stop();
  end
endmodule
